/* File: shared/nand_cmd_pkg.sv */
/*
 Constants and carrier types for the serial NAND command block: opcodes, frame
 bit counts, buffer and remap-table geometry, status bit positions, erase timing.
 Assumes a 50 MHz system clock that oversamples the serial clock.
*/
// Notes on behaviour
// - Factory bad block: non-all-ones byte 0 of page 0, plus spare-area marker.
// - Remap frame: opcode, 16-bit logical block, then 16-bit physical block.
// - Successful remap stores a logical-to-physical link in the kept table.
// - Table holds 20 links; when all used, full flag rises, more refused.
// - Table read: opcode, 8 dummy clocks, then links as logical, physical words.
// - Links come out entry 0 to 19; unused links read as zeros.
// - Logical bits 15:14 are link status: 00 free, 10 valid, 11 invalid.
// - With ECC enabled, programming writes computed ECC into the spare area.
// - Reads update two ECC status bits; 1x means uncorrectable pages seen.
// - Failure page read: opcode, 8 dummy clocks, last failing 16-bit page.
// - Erase: opcode, 8 dummy clocks, 16-bit page; whole 64-page block to ones.
// - Erase and buffer loads are refused unless write enable latch is set.
// - Erase runs only if select rises right after the last address bit.
// - Erase is self-timed; busy high throughout, then latch cleared.
// - Erase of a block in the protected range is skipped.
// - Load: opcode, 16-bit column (low 12 count), data bytes, select held low.
// - Data past the 2112-byte buffer is dropped.
// - Plain load fills unwritten bytes with ones; random load keeps them.
// - All 2112 bytes accepted; ECC engine may overwrite parity bytes.
// - Quad loads mirror plain and random loads, data on four lines.
// - Write-protect enable refuses every quad-lane instruction.
// - Write enable opcode alone in a frame sets the latch.
// - Status reads are accepted at any time, even while busy.
package nand_cmd_pkg;
	localparam int unsigned CLK_MHZ           = 50;
	localparam int unsigned ERASE_DURATION_US = 10;
	localparam int unsigned ERASE_CYCLES      = ERASE_DURATION_US * CLK_MHZ;

	localparam logic [7:0] OP_REMAP      = 8'ha1;
	localparam logic [7:0] OP_TABLE_RD   = 8'ha5;
	localparam logic [7:0] OP_FAIL_PAGE  = 8'ha9;
	localparam logic [7:0] OP_ERASE      = 8'hd8;
	localparam logic [7:0] OP_LOAD       = 8'h02;
	localparam logic [7:0] OP_RAND_LOAD  = 8'h84;
	localparam logic [7:0] OP_QLOAD      = 8'h32;
	localparam logic [7:0] OP_QRAND_LOAD = 8'h34;
	localparam logic [7:0] OP_WREN       = 8'h06;
	localparam logic [7:0] OP_STAT_A     = 8'h0f;
	localparam logic [7:0] OP_STAT_B     = 8'h05;

	localparam logic [14:0] BITS_OPCODE = 15'h0008;
	localparam logic [14:0] BITS_OUT    = 15'h0010;
	localparam logic [14:0] BITS_COLUMN = 15'h0018;
	localparam logic [14:0] BITS_ERASE  = 15'h0020;
	localparam logic [14:0] BITS_REMAP  = 15'h0028;
	localparam logic [14:0] BITS_TABLE  = 15'h0290;

	localparam int unsigned BUF_BYTES  = 2112;
	localparam logic [11:0] BUF_END    = 12'h840;
	localparam logic [7:0]  FILL_BYTE  = 8'hff;
	localparam int unsigned LINKS      = 20;
	localparam logic [4:0]  LINKS_MAX  = 5'h14;
	localparam logic [1:0]  LINK_VALID = 2'h2;
	localparam logic [10:0] BLOCKS     = 11'h400;
	localparam logic [3:0]  BP_ALL     = 4'ha;

	localparam int unsigned ST_BUSY = 0;
	localparam int unsigned ST_WEL  = 1;
	localparam int unsigned ST_ECC0 = 4;
	localparam int unsigned ST_ECC1 = 5;
	localparam int unsigned ST_FULL = 6;

	typedef struct packed
	{
		logic [15:0] logical_blk_addr;
		logic [15:0] physical_blk_addr;
	} link_entry_type;

	typedef struct packed
	{
		logic       cs_n;
		logic       sclk;
		logic [3:0] io;
	} spi_pins_type;
endpackage

/* File: hdl/nand_bbm_erase_load_cmds.sv */
/*
 Serial NAND command block: bad-block remap table, table readback, last ECC
 failure page, block erase and single/quad page-buffer loads.
 Assumes SPI pins arrive asynchronously and the serial clock is well below
 sys_clk / 4; the array, ECC engine and read path sit outside.
*/
`timescale 1ns/1ps
module nand_bbm_erase_load_cmds
(
	input  wire logic                       sys_clk_in,            // 50 MHz clock
	input  wire logic                       rstn_in,               // Async reset, low
	input  wire nand_cmd_pkg::spi_pins_type spi_in,                // Select, clock, IO in
	output logic [3:0]                      io_out,                // IO lines out
	output logic [3:0]                      io_oe_n_out,           // IO enables, low drives
	input  wire logic                       ecc_enable_in,         // Internal ECC on
	input  wire logic [3:0]                 protect_range_bits_in, // Protect size
	input  wire logic                       protect_top_bottom_in, // Protect from bottom
	input  wire logic                       wp_enable_in,          // Quad lockout
	input  wire logic [1:0]                 ecc_status_in,         // Read-path ECC result
	input  wire logic [15:0]                ecc_fail_page_in,      // Last bad ECC page
	input  wire logic [11:0]                buf_rd_addr_in,        // Buffer read address
	output logic [7:0]                      buf_rd_data_out,       // Buffer read data
	input  wire logic                       ecc_wr_en_in,          // Parity byte write
	input  wire logic [11:0]                ecc_wr_addr_in,        // Parity byte address
	input  wire logic [7:0]                 ecc_wr_data_in,        // Parity byte value
	output logic                            erase_req_out,         // Erase start pulse
	output logic [9:0]                      erase_block_out,       // Block to erase
	output logic                            busy_out,              // Erase in progress
	output logic                            write_enable_latch_out, // Latch state
	output logic                            remap_table_full_out   // All links used
);
	typedef enum logic [1:0] {PH_IDLE, PH_OPCODE, PH_BODY} phase_type;

	function automatic logic prot_hit(input logic [3:0] bp, input logic tb,
		input logic [9:0] blk);
		logic [10:0] span;
		span = (bp >= nand_cmd_pkg::BP_ALL) ? nand_cmd_pkg::BLOCKS : (11'h001 << bp);
		if (bp == 4'h0)
			return 1'b0;
		return tb ? ({1'b0, blk} < span) : ({1'b0, blk} >= nand_cmd_pkg::BLOCKS - span);
	endfunction

	function automatic logic is_load(input logic [7:0] op);
		return op == nand_cmd_pkg::OP_LOAD || op == nand_cmd_pkg::OP_RAND_LOAD
			|| op == nand_cmd_pkg::OP_QLOAD || op == nand_cmd_pkg::OP_QRAND_LOAD;
	endfunction

	function automatic logic is_stat(input logic [7:0] op);
		return op == nand_cmd_pkg::OP_STAT_A || op == nand_cmd_pkg::OP_STAT_B;
	endfunction

	function automatic logic is_quad(input logic [7:0] op);
		return op == nand_cmd_pkg::OP_QLOAD || op == nand_cmd_pkg::OP_QRAND_LOAD;
	endfunction

	localparam logic [14:0] BITS_LAST_OP = nand_cmd_pkg::BITS_OPCODE - 15'h0001;

	nand_cmd_pkg::spi_pins_type   sync1, sync2;
	logic                         sclk_d, cs_d;
	phase_type                    phase, next_phase;
	logic [7:0]                   opcode, next_opcode;
	logic [14:0]                  bit_cnt, next_bit_cnt;
	logic [31:0]                  sr, next_sr;
	logic [11:0]                  col, next_col;
	logic [2:0]                   sub, next_sub;
	logic                         cmd_ok, next_cmd_ok;
	logic                         dout, next_dout;
	logic                         drive, next_drive;
	logic                         busy, next_busy;
	logic                         write_enable_latch, next_wel;
	logic [15:0]                  timer, next_timer;
	logic                         erase_req, next_erase_req;
	logic [9:0]                   erase_block, next_erase_block;
	logic [4:0]                   link_cnt, next_link_cnt;
	nand_cmd_pkg::link_entry_type table_q [nand_cmd_pkg::LINKS];
	nand_cmd_pkg::link_entry_type next_table [nand_cmd_pkg::LINKS];
	logic [nand_cmd_pkg::BUF_BYTES-1:0] stale, next_stale;
	logic [7:0]                   mem [nand_cmd_pkg::BUF_BYTES];
	logic                         mem_we;
	logic [11:0]                  mem_addr;
	logic [7:0]                   mem_data;
	logic [7:0]                   next_rd_data;

	logic        sclk_rise, sclk_fall, cs_rise, cs_fall, quad;
	logic [7:0]  new_op, byte_in, stat;
	logic [14:0] idx;
	nand_cmd_pkg::link_entry_type link_out;

	assign sclk_rise = sync2.sclk & ~sclk_d & ~sync2.cs_n;
	assign sclk_fall = ~sync2.sclk & sclk_d & ~sync2.cs_n;
	assign cs_rise   = sync2.cs_n & ~cs_d;
	assign cs_fall   = ~sync2.cs_n & cs_d;
	assign quad      = is_quad(opcode);

	always_comb
	begin
		new_op      = {sr[6:0], sync2.io[0]};
		byte_in     = quad ? {sr[3:0], sync2.io} : {sr[6:0], sync2.io[0]};
		idx         = bit_cnt - nand_cmd_pkg::BITS_OUT;
		link_out    = table_q[idx[9:5]];
		stat        = 8'h00;
		stat[nand_cmd_pkg::ST_BUSY] = busy;
		stat[nand_cmd_pkg::ST_WEL]  = write_enable_latch;
		stat[nand_cmd_pkg::ST_ECC0] = ecc_status_in[0];
		stat[nand_cmd_pkg::ST_ECC1] = ecc_status_in[1];
		stat[nand_cmd_pkg::ST_FULL] = link_cnt == nand_cmd_pkg::LINKS_MAX;

		next_phase       = phase;
		next_opcode      = opcode;
		next_bit_cnt     = bit_cnt;
		next_sr          = sr;
		next_col         = col;
		next_sub         = sub;
		next_cmd_ok      = cmd_ok;
		next_dout        = dout;
		next_drive       = drive;
		next_busy        = busy;
		next_wel         = write_enable_latch;
		next_timer       = timer;
		next_erase_req   = 1'b0;
		next_erase_block = erase_block;
		next_link_cnt    = link_cnt;
		next_table       = table_q;
		next_stale       = stale;
		mem_we           = 1'b0;
		mem_addr         = col;
		mem_data         = byte_in;

		if (busy)
		begin
			if (timer == 16'h0000)
			begin
				next_busy = 1'b0;
				next_wel  = 1'b0;
			end
			else
				next_timer = timer - 16'h0001;
		end

		if (cs_fall)
		begin
			next_phase   = PH_OPCODE;
			next_bit_cnt = 15'h0000;
			next_sub     = 3'h0;
		end

		if (sclk_rise && phase != PH_IDLE)
		begin
			if (bit_cnt != 15'h7fff)
				next_bit_cnt = bit_cnt + 15'h0001;
			next_sr = {sr[30:0], sync2.io[0]};
			if (phase == PH_OPCODE && bit_cnt == BITS_LAST_OP)
			begin
				next_phase  = PH_BODY;
				next_opcode = new_op;
				// While busy only status polling gets through
				next_cmd_ok = is_stat(new_op) || !busy;
				if (is_load(new_op))
				begin
					next_cmd_ok = write_enable_latch && !busy;
					if (wp_enable_in && is_quad(new_op))
						next_cmd_ok = 1'b0;
					// Only the plain loads refill; both random loads keep the buffer
					if (next_cmd_ok && (new_op == nand_cmd_pkg::OP_LOAD
						|| new_op == nand_cmd_pkg::OP_QLOAD))
						next_stale = '1;
				end
			end
			else if (phase == PH_BODY && is_load(opcode))
			begin
				if (bit_cnt < nand_cmd_pkg::BITS_COLUMN)
					next_col = next_sr[11:0];
				else
				begin
					if (quad)
						next_sr = {sr[27:0], sync2.io};
					next_sub = sub + 3'h1;
					if ((quad && sub == 3'h1) || (!quad && sub == 3'h7))
					begin
						next_sub = 3'h0;
						if (cmd_ok && col < nand_cmd_pkg::BUF_END)
						begin
							mem_we            = 1'b1;
							next_stale[col]   = 1'b0;
							next_col          = col + 12'h001;
						end
					end
				end
			end
		end

		if (sclk_fall && phase == PH_BODY && cmd_ok && bit_cnt >= nand_cmd_pkg::BITS_OUT)
		begin
			if (opcode == nand_cmd_pkg::OP_TABLE_RD)
			begin
				next_drive = 1'b1;
				next_dout  = bit_cnt < nand_cmd_pkg::BITS_TABLE
					&& link_out[5'd31 - idx[4:0]];
			end
			else if (opcode == nand_cmd_pkg::OP_FAIL_PAGE)
			begin
				next_drive = 1'b1;
				next_dout  = idx < 15'h0010 && ecc_fail_page_in[4'hf - idx[3:0]];
			end
			else if (is_stat(opcode))
			begin
				next_drive = 1'b1;
				next_dout  = stat[3'h7 - idx[2:0]];
			end
		end

		if (cs_rise)
		begin
			next_phase = PH_IDLE;
			next_drive = 1'b0;
			if (phase == PH_BODY && cmd_ok && !busy)
			begin
				if (opcode == nand_cmd_pkg::OP_WREN && bit_cnt == nand_cmd_pkg::BITS_OPCODE)
					next_wel = 1'b1;
				if (opcode == nand_cmd_pkg::OP_ERASE && bit_cnt == nand_cmd_pkg::BITS_ERASE
					&& write_enable_latch)
				begin
					if (!prot_hit(protect_range_bits_in, protect_top_bottom_in, sr[15:6]))
					begin
						next_erase_block = sr[15:6];
						next_erase_req   = 1'b1;
						next_busy        = 1'b1;
						next_timer       = 16'(nand_cmd_pkg::ERASE_CYCLES - 1);
					end
				end
				if (opcode == nand_cmd_pkg::OP_REMAP && bit_cnt == nand_cmd_pkg::BITS_REMAP
					&& link_cnt != nand_cmd_pkg::LINKS_MAX)
				begin
					next_table[link_cnt].logical_blk_addr  =
						{nand_cmd_pkg::LINK_VALID, sr[29:16]};
					next_table[link_cnt].physical_blk_addr = sr[15:0];
					next_link_cnt = link_cnt + 5'h01;
				end
			end
		end

		// Parity bytes win over a host byte in the same cycle; with ECC off the
		// spare area keeps whatever the host loaded
		if (ecc_wr_en_in && ecc_enable_in)
		begin
			mem_we                     = 1'b1;
			mem_addr                   = ecc_wr_addr_in;
			mem_data                   = ecc_wr_data_in;
			next_stale[ecc_wr_addr_in] = 1'b0;
		end

		// Unwritten bytes read as ones, so a fresh buffer never looks bad-marked
		next_rd_data = mem[buf_rd_addr_in];
		if (stale[buf_rd_addr_in])
			next_rd_data = nand_cmd_pkg::FILL_BYTE;
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (mem_we)
			mem[mem_addr] <= mem_data;
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			sync1           <= '1;
			sync2           <= '1;
			sclk_d          <= 1'b0;
			cs_d            <= 1'b1;
			phase           <= PH_IDLE;
			opcode          <= 8'h00;
			bit_cnt         <= 15'h0000;
			sr              <= 32'h00000000;
			col             <= 12'h000;
			sub             <= 3'h0;
			cmd_ok          <= 1'b0;
			dout            <= 1'b0;
			drive           <= 1'b0;
			busy            <= 1'b0;
			write_enable_latch             <= 1'b0;
			timer           <= 16'h0000;
			erase_req       <= 1'b0;
			erase_block     <= 10'h000;
			link_cnt        <= 5'h00;
			table_q         <= '{default: '0};
			stale           <= '1;
			buf_rd_data_out <= 8'h00;
		end
		else
		begin
			sync1           <= spi_in;
			sync2           <= sync1;
			sclk_d          <= sync2.sclk;
			cs_d            <= sync2.cs_n;
			phase           <= next_phase;
			opcode          <= next_opcode;
			bit_cnt         <= next_bit_cnt;
			sr              <= next_sr;
			col             <= next_col;
			sub             <= next_sub;
			cmd_ok          <= next_cmd_ok;
			dout            <= next_dout;
			drive           <= next_drive;
			busy            <= next_busy;
			write_enable_latch             <= next_wel;
			timer           <= next_timer;
			erase_req       <= next_erase_req;
			erase_block     <= next_erase_block;
			link_cnt        <= next_link_cnt;
			table_q         <= next_table;
			stale           <= next_stale;
			buf_rd_data_out <= next_rd_data;
		end
	end

	// Only the DO line is ever driven; quad lanes are input-only here
	assign io_out                 = {2'b00, dout, 1'b0};
	assign io_oe_n_out            = {2'b11, ~drive, 1'b1};
	assign erase_req_out          = erase_req;
	assign erase_block_out        = erase_block;
	assign busy_out               = busy;
	assign write_enable_latch_out = write_enable_latch;
	assign remap_table_full_out   = link_cnt == nand_cmd_pkg::LINKS_MAX;
endmodule

/* File: bench/nand_bbm_erase_load_cmds_props.sv */
/*
 Concurrent checks on the serial NAND command block: erase timing, latch,
 protection, table-full flag and output enable idle level.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module nand_bbm_erase_load_cmds_props
(
	input wire logic                       sys_clk_in,             // System clock
	input wire logic                       rstn_in,                // Async reset, low
	input wire nand_cmd_pkg::spi_pins_type spi_in,                 // SPI pins
	input wire logic [3:0]                 io_oe_n_out,            // IO enables
	input wire logic [3:0]                 protect_range_bits_in,  // Protect size
	input wire logic                       erase_req_out,          // Erase start
	input wire logic                       busy_out,               // Erase running
	input wire logic                       write_enable_latch_out, // Latch
	input wire logic                       remap_table_full_out    // Table full
);
	logic [9:0] busy_cnt;
	logic [9:0] next_busy_cnt;

	// Counts busy cycles so the erase length is checked to the exact figure
	always_comb
		next_busy_cnt = busy_out ? busy_cnt + 10'h001 : 10'h000;

	always_ff @(posedge sys_clk_in or negedge rstn_in)
		if (!rstn_in)
			busy_cnt <= 10'h000;
		else
			busy_cnt <= next_busy_cnt;

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);

	chk_req_busy: assert property (erase_req_out |-> busy_out)
		else $error("erase start without busy");
	chk_req_single: assert property (erase_req_out |=> !erase_req_out)
		else $error("erase start longer than one cycle");
	chk_busy_cause: assert property ($rose(busy_out) |-> erase_req_out)
		else $error("busy without erase start");
	chk_busy_length: assert property ($fell(busy_out)
		|-> busy_cnt == 10'(nand_cmd_pkg::ERASE_CYCLES)) else $error("erase length wrong");
	chk_wel_cleared: assert property ($fell(busy_out) |-> !write_enable_latch_out)
		else $error("latch not cleared after erase");
	chk_erase_wel: assert property (busy_out |-> write_enable_latch_out)
		else $error("erase running without latch");
	chk_erase_prot: assert property (erase_req_out
		|-> protect_range_bits_in < nand_cmd_pkg::BP_ALL) else $error("protected erase");
	chk_full_held: assert property (remap_table_full_out |=> remap_table_full_out)
		else $error("full flag dropped");
	chk_oe_idle: assert property (spi_in.cs_n [*8] |-> io_oe_n_out == 4'hf)
		else $error("output driven while deselected");
endmodule

bind nand_bbm_erase_load_cmds nand_bbm_erase_load_cmds_props i_props
(
	.sys_clk_in             (sys_clk_in),
	.rstn_in                (rstn_in),
	.spi_in                 (spi_in),
	.io_oe_n_out            (io_oe_n_out),
	.protect_range_bits_in  (protect_range_bits_in),
	.erase_req_out          (erase_req_out),
	.busy_out               (busy_out),
	.write_enable_latch_out (write_enable_latch_out),
	.remap_table_full_out   (remap_table_full_out)
);

/* File: bench/spi_host_model.sv */
/*
 SPI host model: drives select, a 160 ns serial clock and IO, captures DO.
 Assumes its tasks are called just after a rising system clock edge.
*/
`timescale 1ns/1ps
module spi_host_model
(
	input  wire logic                  sys_clk_in, // Bench clock
	input  wire logic [3:0]            io_in,      // Resolved IO lines
	output nand_cmd_pkg::spi_pins_type pins_out,   // Host pins
	output logic [31:0]                rx_out      // Bits seen on DO
);
	initial
	begin
		pins_out = '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
		rx_out = 32'h0;
	end

	// Clock parks low; released lines toggle so stale data never looks valid
	task automatic select(input logic on);
		pins_out.cs_n <= !on;
		pins_out.sclk <= 1'b0;
		pins_out.io <= ~pins_out.io;
		repeat (8) @(posedge sys_clk_in);
	endtask

	// DO is read late in the high phase, well after the device has shifted
	task automatic clk_out(input logic [3:0] o);
		pins_out.sclk <= 1'b0;
		pins_out.io <= o;
		repeat (4) @(posedge sys_clk_in);
		pins_out.sclk <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		rx_out = {rx_out[30:0], io_in[1]};
	endtask

	task automatic byte_out(input logic [7:0] b, input logic quad);
		for (int k = 7; k >= 0; k -= quad ? 4 : 1)
			clk_out(quad ? b[k -: 4] : {~{3{b[k]}}, b[k]});
	endtask
endmodule

/* File: bench/nand_bbm_erase_load_cmds_tb.sv */
/*
 Self-checking bench for the serial NAND command block, driving it through
 the SPI host model and checking buffer, status and readback.
 Assumes the checker is bound by its own file.
*/
`timescale 1ns/1ps
module nand_bbm_erase_load_cmds_tb;
	logic                       sys_clk_in;
	logic                       rstn_in;
	logic                       ecc_enable_in;
	logic                       protect_top_bottom_in;
	logic                       wp_enable_in;
	logic                       ecc_wr_en_in;
	logic                       erase_req_out;
	logic                       busy_out;
	logic                       write_enable_latch_out;
	logic                       remap_table_full_out;
	logic [3:0]                 protect_range_bits_in;
	logic [3:0]                 io_out;
	logic [3:0]                 io_oe_n_out;
	logic [3:0]                 io_res;
	logic [1:0]                 ecc_status_in;
	logic [15:0]                ecc_fail_page_in;
	logic [11:0]                buf_rd_addr_in;
	logic [11:0]                ecc_wr_addr_in;
	logic [7:0]                 buf_rd_data_out;
	logic [7:0]                 ecc_wr_data_in;
	logic [7:0]                 st;
	logic [9:0]                 erase_block_out;
	logic [31:0]                rx;
	nand_cmd_pkg::spi_pins_type pins;
	nand_cmd_pkg::spi_pins_type spi_in;
	int                         bad_count;
	int                         checks;
	int                         cyc;
	int                         i;

	assign io_res = (~io_oe_n_out & io_out) | (io_oe_n_out & pins.io);
	assign spi_in = {pins.cs_n, pins.sclk, io_res};

	nand_bbm_erase_load_cmds i_nand_bbm_erase_load_cmds
	(
		.sys_clk_in (sys_clk_in), .rstn_in (rstn_in), .spi_in (spi_in),
		.io_out (io_out), .io_oe_n_out (io_oe_n_out), .ecc_enable_in (ecc_enable_in),
		.protect_range_bits_in (protect_range_bits_in),
		.protect_top_bottom_in (protect_top_bottom_in), .wp_enable_in (wp_enable_in),
		.ecc_status_in (ecc_status_in), .ecc_fail_page_in (ecc_fail_page_in),
		.buf_rd_addr_in (buf_rd_addr_in), .buf_rd_data_out (buf_rd_data_out),
		.ecc_wr_en_in (ecc_wr_en_in), .ecc_wr_addr_in (ecc_wr_addr_in),
		.ecc_wr_data_in (ecc_wr_data_in), .erase_req_out (erase_req_out),
		.erase_block_out (erase_block_out), .busy_out (busy_out),
		.write_enable_latch_out (write_enable_latch_out),
		.remap_table_full_out (remap_table_full_out)
	);

	spi_host_model i_spi_host_model
	(
		.sys_clk_in (sys_clk_in), .io_in (io_res), .pins_out (pins), .rx_out (rx)
	);

	initial
	begin
		sys_clk_in = 1'b0;
		forever #10 sys_clk_in = ~sys_clk_in;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic send(input logic [7:0] op, input logic [31:0] a, input int nb, input logic q);
		i_spi_host_model.select(1'b1);
		i_spi_host_model.byte_out(op, 1'b0);
		for (int k = nb - 1; k >= 0; k--)
			i_spi_host_model.byte_out(a[8*k +: 8], q && k == 0);
	endtask

	task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int nb, input logic q);
		send(op, a, nb, q);
		i_spi_host_model.select(1'b0);
	endtask

	task automatic status(input logic [7:0] op);
		send(op, 32'h0, 1, 1'b0);
		repeat (8) i_spi_host_model.clk_out(4'h0);
		i_spi_host_model.select(1'b0);
		st = rx[7:0];
	endtask

	task automatic buf_chk(input logic [11:0] a, input logic [7:0] e);
		buf_rd_addr_in <= a;
		repeat (2) @(posedge sys_clk_in);
		check(buf_rd_data_out, e);
	endtask

	task automatic ecc_wr(input logic [11:0] a, input logic [7:0] d);
		ecc_wr_addr_in <= a;
		ecc_wr_data_in <= d;
		ecc_wr_en_in <= 1'b1;
		@(posedge sys_clk_in);
		ecc_wr_en_in <= 1'b0;
	endtask

	task automatic set_prot(input logic [3:0] bp, input logic tb);
		protect_range_bits_in <= bp;
		protect_top_bottom_in <= tb;
	endtask

	task automatic page_chk(input logic [15:0] p);
		ecc_fail_page_in <= p;
		send(nand_cmd_pkg::OP_FAIL_PAGE, 32'h0, 1, 1'b0);
		repeat (16) i_spi_host_model.clk_out(4'h0);
		i_spi_host_model.select(1'b0);
		check(rx[15:0], p);
	endtask

	// Links were sent with status bits 11, so stored ones must read back as 10
	task automatic table_chk(input int n, input int used);
		send(nand_cmd_pkg::OP_TABLE_RD, 32'h0, 1, 1'b0);
		for (int k = 0; k < n; k++)
		begin
			repeat (32) i_spi_host_model.clk_out(4'h0);
			check(rx, k < used ? {16'h8100 + 16'(k), 16'h0300 + 16'(k)} : 32'h0);
		end
		i_spi_host_model.select(1'b0);
	endtask

	initial
	begin
		cyc = 0;
		while (cyc < 40000)
		begin
			@(posedge sys_clk_in);
			cyc++;
		end
		bad_count++;
		$display("CHECK FAILED t=%0t run did not finish", $time);
		end_of_test();
	end

	initial
	begin
		bad_count = 0;
		checks = 0;
		{rstn_in, wp_enable_in, ecc_wr_en_in} = 3'h0;
		ecc_enable_in = 1'b1;
		ecc_status_in = 2'h2;
		set_prot(4'h0, 1'b0);
		repeat (6) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		cmd(nand_cmd_pkg::OP_LOAD, 32'h0005_3c, 3, 1'b0);
		buf_chk(12'h005, 8'hff);
		cmd(nand_cmd_pkg::OP_WREN, 32'h0, 0, 1'b0);
		status(nand_cmd_pkg::OP_STAT_A);
		check(st[1], 1'b1);
		cmd(nand_cmd_pkg::OP_LOAD, 32'hf005_3cc3, 4, 1'b0);
		buf_chk(12'h005, 8'h3c);
		buf_chk(12'h006, 8'hc3);
		buf_chk(12'h000, 8'hff);
		cmd(nand_cmd_pkg::OP_RAND_LOAD, 32'h0000_11, 3, 1'b0);
		buf_chk(12'h005, 8'h3c);
		cmd(nand_cmd_pkg::OP_RAND_LOAD, 32'h083f_2233, 4, 1'b0);
		buf_chk(12'h83f, 8'h22);
		buf_chk(12'h000, 8'h11);
		wp_enable_in <= 1'b1;
		cmd(nand_cmd_pkg::OP_QLOAD, 32'h0007_5a, 3, 1'b1);
		buf_chk(12'h000, 8'h11);
		wp_enable_in <= 1'b0;
		cmd(nand_cmd_pkg::OP_QLOAD, 32'h0007_5a, 3, 1'b1);
		buf_chk(12'h007, 8'h5a);
		buf_chk(12'h000, 8'hff);
		cmd(nand_cmd_pkg::OP_QRAND_LOAD, 32'h0008_6b, 3, 1'b1);
		buf_chk(12'h008, 8'h6b);
		buf_chk(12'h007, 8'h5a);
		ecc_wr(12'h820, 8'h99);
		buf_chk(12'h820, 8'h99);
		ecc_enable_in <= 1'b0;
		ecc_wr(12'h821, 8'h77);
		buf_chk(12'h821, 8'hff);
		ecc_enable_in <= 1'b1;
		page_chk(16'h0a5c);
		page_chk(16'hc3a5);
		set_prot(4'ha, 1'b0);
		cmd(nand_cmd_pkg::OP_ERASE, 32'h001234, 3, 1'b0);
		check({busy_out, write_enable_latch_out}, 2'h1);
		set_prot(4'h7, 1'b1);
		cmd(nand_cmd_pkg::OP_ERASE, 32'h001234, 3, 1'b0);
		check({busy_out, write_enable_latch_out}, 2'h1);
		set_prot(4'h7, 1'b0);
		cmd(nand_cmd_pkg::OP_ERASE, 32'h00123400, 4, 1'b0);
		check(busy_out, 1'b0);
		cmd(nand_cmd_pkg::OP_ERASE, 32'h001234, 3, 1'b0);
		check({busy_out, erase_block_out}, 11'h448);
		status(nand_cmd_pkg::OP_STAT_B);
		check(st[5:0], 6'h23);
		i = 0;
		while (busy_out && i < 600)
		begin
			@(negedge sys_clk_in);
			i++;
		end
		@(posedge sys_clk_in);
		check({busy_out, write_enable_latch_out}, 2'h0);
		cmd(nand_cmd_pkg::OP_ERASE, 32'h001234, 3, 1'b0);
		check(busy_out, 1'b0);
		for (i = 0; i < 21; i++)
		begin
			cmd(nand_cmd_pkg::OP_REMAP, {16'hc100 + 16'(i), 16'h0300 + 16'(i)}, 4, 1'b0);
			if (i == 1)
				table_chk(3, 2);
			if (i >= 18)
				check(remap_table_full_out, i >= 19);
		end
		table_chk(21, 20);
		ecc_status_in <= 2'h3;
		status(nand_cmd_pkg::OP_STAT_A);
		check(st[6:4], 3'h7);
		end_of_test();
	end
endmodule
